// File: hdl/faxm_pkg.sv
// package: constants, register map and channel carriers of the fetch read master
// What this block does
// RQ1: write-address valid toward the fetch bus is held low at all times.
// RQ2: write-data valid toward the fetch bus is held low at all times.
// RQ3: write-response ready on the fetch bus is held low at all times.
// RQ4: only reads are issued; write channel ports exist but stay disabled.
// RQ5: every read request carries burst length zero, a single beat.
// RQ6: every read request carries size code three, eight-byte beats.
// RQ7: every read request carries the incrementing burst type code.
// RQ8: every read request is a normal access, lock bit zero.
// RQ9: every read request marks cacheable, bufferable, allocating, cache field all ones.
// RQ10: every read request carries protection code for unprivileged secure instruction.
// RQ11: every read request carries quality-of-service zero.
// RQ12: exactly one system bus protocol per build; this build carries AXI4 only.
// RQ13: nmi, timer and external interrupt inputs are resynchronised before use.
// RQ14: reset vector input gives bits 31:1 of the first fetch after reset.
// RQ15: nmi vector input gives bits 31:1 of the nmi handler fetch.
// RQ16: active-low reset indication, low in reset and during debug-requested reset.
// RQ17: four separate bus clock enables; only the fetch enable gates logic, the other three are only read back in status.
// RQ18: fetch bus signals launched and sampled only on enabled clock edges.
// RQ19: each async input uses two flops; sender holds it two clock cycles.
// RQ20: all flops reset asynchronously; reset released synchronously by the outside. The tag table entries (mem_ff) have no reset.
// RQ21: write ready and response inputs ignored; read data matched by read id.
// RQ22: read request held stable from valid until ready on enabled edge.
package faxm_pkg;

    localparam int fetch_id_width_param = 3;
    localparam int irq_count_param      = 8;
    localparam int id_count             = 1 << fetch_id_width_param;
    localparam int sync_width           = irq_count_param + 2;

    // fixed read request attributes
    localparam logic [7:0] ar_len    = 8'h00;
    localparam logic [2:0] ar_size   = 3'h3;
    localparam logic [1:0] ar_burst  = 2'h1;
    localparam logic       ar_lock   = 1'h0;
    localparam logic [3:0] ar_cache  = 4'hf;
    localparam logic [2:0] ar_prot   = 3'h4;
    localparam logic [3:0] ar_qos    = 4'h0;
    localparam logic [3:0] ar_region = 4'h0;
    localparam logic [1:0] resp_okay = 2'h0;

    // register map, byte addresses
    localparam int          apb_addr_width = 12;
    localparam logic [11:0] off_ctrl       = 12'h000;
    localparam logic [11:0] off_fetch_addr = 12'h004;
    localparam logic [11:0] off_status     = 12'h008;
    localparam logic [11:0] off_rdata_lo   = 12'h00c;
    localparam logic [11:0] off_rdata_hi   = 12'h010;
    localparam logic [11:0] off_rinfo      = 12'h014;
    localparam logic [11:0] off_raddr      = 12'h018;
    localparam logic [11:0] off_irq        = 12'h01c;
    localparam logic [11:0] off_rst_vec    = 12'h020;
    localparam logic [11:0] off_nmi_vec    = 12'h024;

    // ctrl fields
    localparam int         ctrl_en_bit     = 0;
    localparam int         ctrl_dbgrst_bit = 1;
    localparam logic [1:0] ctrl_rst_val    = 2'h1;

    // status fields
    localparam int st_busy_lsb   = 0;
    localparam int st_arvalid    = 8;
    localparam int st_pend       = 9;
    localparam int st_nmi_pend   = 10;
    localparam int st_sw_pend    = 11;
    localparam int st_resp_err   = 12;
    localparam int st_stray      = 13;
    localparam int st_clk_en_lsb = 14;

    // rinfo fields
    localparam int rinfo_resp_lsb  = 3;
    localparam int rinfo_last      = 5;
    localparam int rinfo_count_lsb = 16;

    typedef struct packed {
        logic [fetch_id_width_param-1:0] id;
        logic [31:0]                     addr;
        logic [7:0]                      len;
        logic [2:0]                      size;
        logic [1:0]                      burst;
        logic                            lock;
        logic [3:0]                      cache;
        logic [2:0]                      prot;
        logic [3:0]                      qos;
        logic [3:0]                      region;
    } faxm_addr_t;

    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  strb;
        logic        last;
    } faxm_w_t;

    typedef struct packed {
        logic [fetch_id_width_param-1:0] id;
        logic [1:0]                      resp;
    } faxm_b_t;

    typedef struct packed {
        logic [fetch_id_width_param-1:0] id;
        logic [63:0]                     data;
        logic [1:0]                      resp;
        logic                            last;
    } faxm_r_t;

endpackage

// File: hdl/faxm_tag_ram.sv
// file: table of request addresses indexed by read id, registered read
`timescale 1ns/100ps
`default_nettype none
module faxm_tag_ram (
    input  wire logic                                     i_ref_clk,
    input  wire logic                                     i_rst_n,
    input  wire logic                                     i_wr_en,
    input  wire logic [faxm_pkg::fetch_id_width_param-1:0] i_wr_idx,
    input  wire logic [31:0]                              i_wr_data,
    input  wire logic                                     i_rd_en,
    input  wire logic [faxm_pkg::fetch_id_width_param-1:0] i_rd_idx,
    output logic      [31:0]                              o_rd_data
);

    logic [31:0] mem_ff [faxm_pkg::id_count];
    logic [31:0] rd_data_ff;

    always_ff @(posedge i_ref_clk) begin
        if (i_wr_en) begin
            mem_ff[i_wr_idx] <= i_wr_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data_ff <= 32'h0000_0000;
        end else if (i_rd_en) begin
            rd_data_ff <= mem_ff[i_rd_idx];
        end
    end

    assign o_rd_data = rd_data_ff;

endmodule // faxm_tag_ram
`default_nettype wire

// File: hdl/faxm_fetch_port.sv
// file: fetch read master port with apb control and status
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module faxm_fetch_port (
    input  wire logic                                     i_ref_clk,
    input  wire logic                                     i_rst_n,
    // bus clock enables
    input  wire logic                                     i_fetch_bus_clk_en,
    input  wire logic                                     i_lsu_bus_clk_en,
    input  wire logic                                     i_dbg_bus_clk_en,
    input  wire logic                                     i_dma_bus_clk_en,
    // vectors and reset indication
    input  wire logic [31:1]                              i_rst_vec,
    input  wire logic [31:1]                              i_nmi_vec,
    output logic                                          o_core_rst_n,
    // asynchronous interrupts and their synchronised levels
    input  wire logic                                     i_nmi_int,
    input  wire logic                                     i_timer_int,
    input  wire logic [faxm_pkg::irq_count_param:1]       i_ext_irq,
    output logic                                          o_nmi_sync,
    output logic                                          o_timer_sync,
    output logic      [faxm_pkg::irq_count_param:1]       o_ext_irq_sync,
    // fetch axi4 write channels, disabled
    output logic                                          o_awvalid,
    input  wire logic                                     i_awready,
    output faxm_pkg::faxm_addr_t                          o_aw,
    output logic                                          o_wvalid,
    input  wire logic                                     i_wready,
    output faxm_pkg::faxm_w_t                             o_w,
    input  wire logic                                     i_bvalid,
    output logic                                          o_bready,
    input  wire faxm_pkg::faxm_b_t                        i_b,
    // fetch axi4 read channels
    output logic                                          o_arvalid,
    input  wire logic                                     i_arready,
    output faxm_pkg::faxm_addr_t                          o_ar,
    input  wire logic                                     i_rvalid,
    output logic                                          o_rready,
    input  wire faxm_pkg::faxm_r_t                        i_r,
    // apb slave
    input  wire logic                                     i_psel,
    input  wire logic                                     i_penable,
    input  wire logic                                     i_pwrite,
    input  wire logic [faxm_pkg::apb_addr_width-1:0]      i_paddr,
    input  wire logic [31:0]                              i_pwdata,
    output logic      [31:0]                              o_prdata,
    output logic                                          o_pready,
    output logic                                          o_pslverr
);

    localparam int idw = faxm_pkg::fetch_id_width_param;

    // ------------------------------------------------------------
    // interrupt synchronisers
    // ------------------------------------------------------------
    logic [faxm_pkg::sync_width-1:0] async_in;
    logic [faxm_pkg::sync_width-1:0] sync1_ff;
    logic [faxm_pkg::sync_width-1:0] sync2_ff;
    logic                            nmi_dly_ff;
    logic                            nmi_edge;

    assign async_in = {i_ext_irq, i_timer_int, i_nmi_int};

    genvar g;
    generate
        for (g = 0; g < faxm_pkg::sync_width; g++) begin : g_sync
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync1_ff[g] <= 1'b0;
                    sync2_ff[g] <= 1'b0;
                end else begin
                    sync1_ff[g] <= async_in[g]; // RQ13 RQ19
                    sync2_ff[g] <= sync1_ff[g]; // RQ19
                end
            end
        end
    endgenerate

    assign o_nmi_sync     = sync2_ff[0];
    assign o_timer_sync   = sync2_ff[1];
    assign o_ext_irq_sync = sync2_ff[faxm_pkg::sync_width-1:2];
    assign nmi_edge       = sync2_ff[0] & ~nmi_dly_ff; // RQ13

    // ------------------------------------------------------------
    // write channels, tied off
    // ------------------------------------------------------------
    assign o_awvalid = 1'b0; // RQ1 RQ4
    assign o_wvalid  = 1'b0; // RQ2 RQ4
    assign o_bready  = 1'b0; // RQ3 RQ4
    assign o_aw      = '0;   // RQ4
    assign o_w       = '0;   // RQ4

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic        ack_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic        access;
    logic        wr_take;
    logic        hit_ctrl;
    logic        hit_fetch;
    logic        hit_status;
    logic        addr_hit;
    logic [31:0] rd_mux;

    assign access     = i_psel & i_penable;
    assign wr_take    = access & ack_ff & i_pwrite;
    assign hit_ctrl   = i_paddr == faxm_pkg::off_ctrl;
    assign hit_fetch  = i_paddr == faxm_pkg::off_fetch_addr;
    assign hit_status = i_paddr == faxm_pkg::off_status;
    assign addr_hit   = hit_ctrl | hit_fetch | hit_status
                      | (i_paddr == faxm_pkg::off_rdata_lo) | (i_paddr == faxm_pkg::off_rdata_hi)
                      | (i_paddr == faxm_pkg::off_rinfo) | (i_paddr == faxm_pkg::off_raddr)
                      | (i_paddr == faxm_pkg::off_irq) | (i_paddr == faxm_pkg::off_rst_vec)
                      | (i_paddr == faxm_pkg::off_nmi_vec);
    assign o_pready   = ack_ff;
    assign o_prdata   = prdata_ff;
    assign o_pslverr  = pslverr_ff;

    // ------------------------------------------------------------
    // control register and reset indication
    // ------------------------------------------------------------
    logic [1:0]  ctrl_ff;
    logic        core_rst_n_ff;
    logic        fetch_en;
    logic        run;

    assign fetch_en     = ctrl_ff[faxm_pkg::ctrl_en_bit];
    assign run          = core_rst_n_ff;
    assign o_core_rst_n = core_rst_n_ff; // RQ16

    // ------------------------------------------------------------
    // request slot and id bookkeeping
    // ------------------------------------------------------------
    logic                  boot_pend_ff;
    logic                  nmi_pend_ff;
    logic                  sw_pend_ff;
    logic [31:0]           sw_addr_ff;
    logic                  pend_ff;
    logic [31:0]           pend_addr_ff;
    logic                  arvalid_ff;
    logic [31:0]           araddr_ff;
    logic [idw-1:0]        arid_ff;
    logic [idw-1:0]        next_id_ff;
    logic [faxm_pkg::id_count-1:0] busy_ff;
    logic                  issue;
    logic                  ar_fire;
    logic                  r_fire;
    logic                  load_slot;
    logic [31:0]           load_addr;
    logic                  stray;
    logic                  resp_err;
    logic [faxm_pkg::id_count-1:0] set_busy;
    logic [faxm_pkg::id_count-1:0] clr_busy;

    assign ar_fire   = arvalid_ff & i_arready & i_fetch_bus_clk_en; // RQ18 RQ22
    assign issue     = i_fetch_bus_clk_en & run & pend_ff & ~arvalid_ff & ~busy_ff[next_id_ff]; // RQ18
    assign o_rready  = 1'b1;
    assign r_fire    = i_rvalid & i_fetch_bus_clk_en; // RQ18
    assign stray     = r_fire & ~busy_ff[i_r.id]; // RQ21
    assign resp_err  = r_fire & (i_r.resp != faxm_pkg::resp_okay);
    assign load_slot = run & (~pend_ff | issue) & (boot_pend_ff | nmi_pend_ff | (sw_pend_ff & fetch_en));
    assign load_addr = boot_pend_ff ? {i_rst_vec, 1'b0} : // RQ14
                       nmi_pend_ff  ? {i_nmi_vec, 1'b0} : // RQ15
                       sw_addr_ff;
    assign set_busy  = issue ? (faxm_pkg::id_count)'(1) << next_id_ff : '0;
    assign clr_busy  = r_fire ? (faxm_pkg::id_count)'(1) << i_r.id : '0; // RQ21

    // fixed read attributes, id and address from flops
    assign o_arvalid    = arvalid_ff;
    assign o_ar.id      = arid_ff;
    assign o_ar.addr    = araddr_ff;
    assign o_ar.len     = faxm_pkg::ar_len;    // RQ5
    assign o_ar.size    = faxm_pkg::ar_size;   // RQ6
    assign o_ar.burst   = faxm_pkg::ar_burst;  // RQ7
    assign o_ar.lock    = faxm_pkg::ar_lock;   // RQ8
    assign o_ar.cache   = faxm_pkg::ar_cache;  // RQ9
    assign o_ar.prot    = faxm_pkg::ar_prot;   // RQ10
    assign o_ar.qos     = faxm_pkg::ar_qos;    // RQ11
    assign o_ar.region  = faxm_pkg::ar_region; // RQ12

    // ------------------------------------------------------------
    // read return capture
    // ------------------------------------------------------------
    logic [63:0]  rdata_ff;
    logic [5:0]   rinfo_ff;
    logic [15:0]  count_ff;
    logic         rnew_ff;
    logic [31:0]  raddr_ff;
    logic [31:0]  tag_q;
    logic         err_ff;
    logic         stray_ff;
    logic [31:0]  status_word;

    faxm_tag_ram u_tag_ram (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (issue),
        .i_wr_idx  (next_id_ff),
        .i_wr_data (pend_addr_ff),
        .i_rd_en   (r_fire),
        .i_rd_idx  (i_r.id),
        .o_rd_data (tag_q)
    );

    assign status_word = {14'h0000,
                          i_dma_bus_clk_en, i_dbg_bus_clk_en, i_lsu_bus_clk_en, i_fetch_bus_clk_en, // RQ17
                          stray_ff, err_ff, sw_pend_ff, nmi_pend_ff, pend_ff, arvalid_ff, busy_ff};

    assign rd_mux = hit_ctrl   ? {30'h0000_0000, ctrl_ff} :
                    hit_fetch  ? sw_addr_ff :
                    hit_status ? status_word :
                    (i_paddr == faxm_pkg::off_rdata_lo) ? rdata_ff[31:0] :
                    (i_paddr == faxm_pkg::off_rdata_hi) ? rdata_ff[63:32] :
                    (i_paddr == faxm_pkg::off_rinfo)    ? {count_ff, 10'h000, rinfo_ff} :
                    (i_paddr == faxm_pkg::off_raddr)    ? raddr_ff :
                    (i_paddr == faxm_pkg::off_irq)      ? {22'h00_0000, sync2_ff} :
                    (i_paddr == faxm_pkg::off_rst_vec)  ? {i_rst_vec, 1'b0} :
                    (i_paddr == faxm_pkg::off_nmi_vec)  ? {i_nmi_vec, 1'b0} :
                    32'h0000_0000;

    // ------------------------------------------------------------
    // flops, all reset asynchronously
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin // RQ20
            ack_ff     <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            ack_ff <= access & ~ack_ff;
            if (access & ~ack_ff) begin
                prdata_ff  <= (i_pwrite | ~addr_hit) ? 32'h0000_0000 : rd_mux;
                pslverr_ff <= ~addr_hit;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_ff       <= faxm_pkg::ctrl_rst_val;
            core_rst_n_ff <= 1'b0;
            nmi_dly_ff    <= 1'b0;
        end else begin
            if (wr_take & hit_ctrl) begin
                ctrl_ff <= i_pwdata[1:0];
            end
            core_rst_n_ff <= ~ctrl_ff[faxm_pkg::ctrl_dbgrst_bit]; // RQ16
            nmi_dly_ff    <= sync2_ff[0];
        end
    end

    // pending sources: set wins over the clear by loading
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boot_pend_ff <= 1'b1;
            nmi_pend_ff  <= 1'b0;
            sw_pend_ff   <= 1'b0;
            sw_addr_ff   <= 32'h0000_0000;
        end else begin
            boot_pend_ff <= ~run | (boot_pend_ff & ~load_slot); // RQ14 RQ16
            nmi_pend_ff  <= run & (nmi_edge | (nmi_pend_ff & ~(load_slot & ~boot_pend_ff))); // RQ15
            sw_pend_ff   <= run & ((wr_take & hit_fetch)
                          | (sw_pend_ff & ~(load_slot & ~boot_pend_ff & ~nmi_pend_ff)));
            if (wr_take & hit_fetch) begin
                sw_addr_ff <= i_pwdata;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_ff      <= 1'b0;
            pend_addr_ff <= 32'h0000_0000;
            arvalid_ff   <= 1'b0;
            araddr_ff    <= 32'h0000_0000;
            arid_ff      <= '0;
            next_id_ff   <= '0;
        end else begin
            pend_ff <= run & (load_slot | (pend_ff & ~issue));
            if (load_slot) begin
                pend_addr_ff <= load_addr;
            end
            if (issue) begin
                arvalid_ff <= 1'b1;
                araddr_ff  <= pend_addr_ff;
                arid_ff    <= next_id_ff;
                next_id_ff <= next_id_ff + 1'b1;
            end else if (ar_fire) begin
                arvalid_ff <= 1'b0; // RQ22
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_ff  <= '0;
            err_ff   <= 1'b0;
            stray_ff <= 1'b0;
        end else begin
            busy_ff  <= (busy_ff & ~clr_busy) | set_busy; // RQ21
            err_ff   <= resp_err | (err_ff & ~(wr_take & hit_status & i_pwdata[faxm_pkg::st_resp_err]));
            stray_ff <= stray | (stray_ff & ~(wr_take & hit_status & i_pwdata[faxm_pkg::st_stray]));
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 64'h0000_0000_0000_0000;
            rinfo_ff <= 6'h00;
            count_ff <= 16'h0000;
            rnew_ff  <= 1'b0;
            raddr_ff <= 32'h0000_0000;
        end else begin
            rnew_ff <= r_fire;
            if (r_fire) begin
                rdata_ff <= i_r.data;
                rinfo_ff <= {i_r.last, i_r.resp, i_r.id}; // RQ21
                count_ff <= count_ff + 16'h0001;
            end
            if (rnew_ff) begin
                raddr_ff <= tag_q; // RQ21
            end
        end
    end

endmodule // faxm_fetch_port
`default_nettype wire

// File: test/faxm_chk.sv
// checker: fetch bus relations, bound to the fetch port
`timescale 1ns/100ps
`default_nettype none
module faxm_chk (
    input wire logic                 i_ref_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_fetch_bus_clk_en,
    input wire logic                 i_nmi_int,
    input wire logic                 o_nmi_sync,
    input wire logic                 o_awvalid,
    input wire logic                 o_wvalid,
    input wire logic                 o_bready,
    input wire logic                 o_arvalid,
    input wire logic                 i_arready,
    input wire faxm_pkg::faxm_addr_t o_ar
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_aw_off: assert property (!o_awvalid) else $error("write address valid seen");
    a_w_off: assert property (!o_wvalid) else $error("write data valid seen");
    a_b_off: assert property (!o_bready) else $error("write response ready seen");
    a_ar_fixed: assert property (o_arvalid |-> o_ar.len == 8'h00 && o_ar.size == 3'h3 &&
        o_ar.burst == 2'h1 && !o_ar.lock && o_ar.cache == 4'hf && o_ar.prot == 3'h4 && o_ar.qos == 4'h0)
        else $error("read attributes wrong");
    a_ar_hold: assert property (o_arvalid && !(i_arready && i_fetch_bus_clk_en) |=> o_arvalid && $stable(o_ar))
        else $error("read request changed before accept");
    a_ar_drop: assert property (o_arvalid && i_arready && i_fetch_bus_clk_en |=> !o_arvalid)
        else $error("read request kept after accept");
    a_ar_gate: assert property (!i_fetch_bus_clk_en |=> !$rose(o_arvalid))
        else $error("read request launched on idle edge");
    a_nmi_sync: assert property (o_nmi_sync == $past(i_nmi_int, 2))
        else $error("nmi sync delay wrong");
    c_ar_taken: cover property (o_arvalid && i_arready && i_fetch_bus_clk_en);
    c_ar_wait: cover property (o_arvalid && !i_fetch_bus_clk_en);
    c_nmi: cover property ($rose(o_nmi_sync));
endmodule // faxm_chk
bind faxm_fetch_port faxm_chk chk (.*);
`default_nettype wire

// File: test/faxm_slave.sv
// model: read slave on the fetch bus, prompt or slow accept
`timescale 1ns/100ps
`default_nettype none
module faxm_slave (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_en,
    input  wire logic                 i_slow,
    input  wire logic                 i_arvalid,
    input  wire faxm_pkg::faxm_addr_t i_ar,
    output logic                      o_arready,
    output logic                      o_rvalid,
    output faxm_pkg::faxm_r_t         o_r
);
    logic wait_ff;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_arready, o_rvalid, wait_ff} <= 3'h0;
            o_r <= '0;
        end else if (i_en) begin
            {o_arready, o_rvalid} <= 2'h0;
            wait_ff <= !wait_ff;
            o_r <= ~o_r; // idle lines keep moving
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'h1;
                o_r <= '{i_ar.id, {i_ar.addr, ~i_ar.addr}, faxm_pkg::resp_okay, 1'h1};
            end else if (i_arvalid && !o_rvalid)
                o_arready <= !i_slow || wait_ff;
        end
    end
endmodule // faxm_slave
`default_nettype wire

// File: test/faxm_fetch_port_tb_top.sv
// bench: fetch port against the read slave, apb control and status
`timescale 1ns/100ps
`default_nettype none
module faxm_fetch_port_tb_top;
    logic i_ref_clk = 0, i_rst_n = 0, i_fetch_bus_clk_en = 1, i_lsu_bus_clk_en = 0, i_dbg_bus_clk_en = 0;
    logic i_dma_bus_clk_en = 0, i_nmi_int = 0, i_timer_int = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic i_awready = 1, i_wready = 1, i_bvalid = 1, i_arready, i_rvalid, slow = 0, e, o_core_rst_n;
    logic o_nmi_sync, o_timer_sync, o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_pready, o_pslverr;
    logic [31:1]                        i_rst_vec = 31'h0000_2000, i_nmi_vec = 31'h0000_0400;
    logic [faxm_pkg::irq_count_param:1] i_ext_irq = 0, o_ext_irq_sync;
    logic [11:0]                        i_paddr = 0;
    logic [31:0]                        i_pwdata = 0, o_prdata, q;
    logic [2:0]                         ratio = 0, div = 0;
    int                                 n_fail = 0, compares = 0;
    faxm_pkg::faxm_addr_t               o_aw, o_ar;
    faxm_pkg::faxm_w_t                  o_w;
    faxm_pkg::faxm_b_t                  i_b = '1;
    faxm_pkg::faxm_r_t                  i_r;
    faxm_fetch_port uut (.*);
    faxm_slave sl (.i_ref_clk, .i_rst_n, .i_en(i_fetch_bus_clk_en), .i_slow(slow), .i_arvalid(o_arvalid),
        .i_ar(o_ar), .o_arready(i_arready), .o_rvalid(i_rvalid), .o_r(i_r));
    always #50 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        div <= (div == ratio) ? 3'h0 : div + 3'h1;
        i_fetch_bus_clk_en <= (div == ratio);
    end
    initial begin
        #2_000_000;
        n_fail++;
        finish_test();
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_ref_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'h1, w, a, d};
        @(posedge i_ref_clk);
        i_penable <= 1'h1;
        do @(posedge i_ref_clk); while (o_pready !== 1'h1 && ++n < 20);
        {q, e} = {o_prdata, o_pslverr};
        n_fail += (n >= 20);
        {i_psel, i_penable} <= 2'h0;
    endtask
    task automatic fetch(input logic [31:0] x);
        int n = 0;
        do @(negedge i_ref_clk); while (o_arvalid !== 1'h1 && ++n < 300);
        chk("araddr", o_ar.addr, x);
        chk("arattr", {o_ar.len, o_ar.size, o_ar.burst, o_ar.lock, o_ar.cache, o_ar.prot, o_ar.qos},
            {8'h00, 3'h3, 2'h1, 1'h0, 4'hf, 3'h4, 4'h0});
        do @(negedge i_ref_clk); while (!(i_rvalid === 1'h1 && i_fetch_bus_clk_en) && ++n < 300);
        n_fail += (n >= 300);
        repeat (3) @(negedge i_ref_clk);
        apb(1'h0, faxm_pkg::off_rdata_hi, '0);
        chk("rdata_hi", q, x);
        apb(1'h0, faxm_pkg::off_raddr, '0);
        chk("raddr", q, x);
    endtask
    task automatic t_boot();
        fetch({i_rst_vec, 1'h0});
        chk("core_rst_n", o_core_rst_n, 1);
        $display("boot test done");
    endtask
    task automatic t_ratio();
        for (int k = 0; k < 2; k++) begin
            ratio <= k ? 3'h7 : 3'h2;
            slow <= 1'h1;
            apb(1'h1, faxm_pkg::off_fetch_addr, 32'h0000_1230 + k * 8);
            fetch(32'h0000_1230 + k * 8);
        end
        {ratio, slow} <= 4'h0;
        $display("ratio test done");
    endtask
    task automatic t_irq();
        @(posedge i_ref_clk);
        {i_ext_irq, i_timer_int, i_nmi_int} <= {8'ha5, 2'h3};
        repeat (2) @(posedge i_ref_clk);
        i_nmi_int <= 1'h0;
        fetch({i_nmi_vec, 1'h0});
        apb(1'h0, faxm_pkg::off_irq, '0);
        chk("irq", q, 32'h0000_0296);
        {i_ext_irq, i_timer_int} <= 9'h000;
        $display("interrupt test done");
    endtask
    task automatic t_dbg();
        apb(1'h1, faxm_pkg::off_ctrl, 32'h0000_0003);
        repeat (2) @(negedge i_ref_clk);
        chk("core_rst_n", o_core_rst_n, 0);
        apb(1'h1, faxm_pkg::off_ctrl, 32'h0000_0001);
        fetch({i_rst_vec, 1'h0});
        $display("debug reset test done");
    endtask
    task automatic t_regs();
        {i_lsu_bus_clk_en, i_dma_bus_clk_en} <= 2'h3;
        apb(1'h0, faxm_pkg::off_status, '0);
        chk("clk_en", q[17:14], 4'hb);
        apb(1'h0, faxm_pkg::off_ctrl, '0);
        chk("ctrl", q, 32'h0000_0001);
        apb(1'h0, 12'hffc, '0);
        chk("slverr", e, 1);
        chk("unmapped", q, 0);
        $display("register test done");
    endtask
    initial begin
        repeat (8) @(posedge i_ref_clk);
        chk("core_rst_n", o_core_rst_n, 0);
        i_rst_n <= 1'h1;
        t_boot();
        t_ratio();
        t_irq();
        t_dbg();
        t_regs();
        finish_test();
    end
endmodule // faxm_fetch_port_tb_top
`default_nettype wire
